// ===== core/smm_consts.svh
// What this block does
// R01: First lockup expiry raises system management interrupt
// R02: Second lockup expiry requests full system reset
// R03: Missing first fetch after reset reboots system
// R04: Memory error message picks interrupt to raise
// R05: Separate disable bit for seven integrated functions
// R06: Disabled function stops claiming bus accesses
// R07: Disabled function raises no interrupts or wake events
// R08: Case intrusion raises interrupt per routing select
// R09: Reload clears first expiry and restarts count
// R10: Intrusion input active low, synchronised first
//
// Purpose: Offsets, field positions, reset values and timing for the monitor
// Assumes: Word addressed Avalon-MM, 32-bit data
// Notes: Fetch wait time is a plain default; override the module parameter
`ifndef SMM_CONSTS_SVH
`define SMM_CONSTS_SVH
// Word indices of the registers
`define SMM_REG_CTRL 3'h0
`define SMM_REG_RELOAD 3'h1
`define SMM_REG_KICK 3'h2
`define SMM_REG_STATUS 3'h3
`define SMM_REG_CLEAR 3'h4
`define SMM_REG_ENABLE 3'h5
`define SMM_REG_FDIS 3'h6
`define SMM_REG_COUNT 3'h7
// Control fields
`define SMM_CTRL_RUN 0
`define SMM_CTRL_ROUTE 1
// Status bit positions
`define SMM_ST_EXP1 0
`define SMM_ST_EXP2 1
`define SMM_ST_NOFETCH 2
`define SMM_ST_ECC_SMI 3
`define SMM_ST_ECC_NMI 4
`define SMM_ST_ECC_SYSTEM_ERROR_N 5
`define SMM_ST_ECC_LT 6
`define SMM_ST_INTRUDE 7
// Reset values
`define SMM_RELOAD_RST 32'h0000_FFFF
`define SMM_ZERO32 32'h0000_0000
// Timing
`define SMM_CLK_MHZ 250
`define SMM_FETCH_WAIT_US 1000
`define SMM_FETCH_WAIT_CYC (`SMM_FETCH_WAIT_US * `SMM_CLK_MHZ)
`endif

// ===== core/smm_monitor.sv
// Purpose: Lockup timer, first fetch check, error routing, function disable
// Assumes: All inputs synchronous to clk except intruder_n and rst_n
// Notes: Event outputs are one-cycle pulses from flip-flops
`include "smm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module smm_monitor
	import smm_pkg::*;
#(
	parameter logic [31:0] FETCH_WAIT_CYC = `SMM_FETCH_WAIT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic first_fetch,
	input wire logic ecc_msg_valid,
	input wire smm_ecc_t ecc_msg_kind,
	input wire logic intruder_n,
	input wire smm_func_t func_in,
	output smm_func_t func_out,
	output logic system_mgmt_interrupt_n,
	output logic nmi,
	output logic system_error_n,
	output logic lockup_timer_irq,
	output logic sys_reset,
	output logic irq
);

	logic [2:0] rst_sync_ff; // Reset release chain, top bit gates the checks
	logic rst_n_int; // Synchronised reset
	smm_state_t state_ff; // Registered state
	smm_state_t nxt_state; // Next state
	logic tmr_exp; // Timer at zero while running
	logic fetch_to; // First fetch wait ran out
	logic intr_hit; // Intrusion became active
	logic ecc_smi, ecc_nmi, ecc_system_error_n, ecc_lt; // Decoded messages
	logic wr_go; // Write taken this edge
	logic kick_go; // Kick write taken this edge
	logic [7:0] st_set; // Status events

	// Release reset through two flops, assert at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 3'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[1:0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync_ff[1];

	// Decode of one message kind, used four times
	function automatic logic ecc_is(input logic v, input smm_ecc_t k, input smm_ecc_t want);
		ecc_is = v && (k == want);
	endfunction : ecc_is

	// Event decode
	always_comb begin
		wr_go = avs_write && state_ff.ack;
		kick_go = wr_go && (avs_address == `SMM_REG_KICK); // R09
		// A kick on the expiry edge wins: no pulse, no reset
		tmr_exp = state_ff.run && (state_ff.count == `SMM_ZERO32) && !kick_go; // R09
		fetch_to = !state_ff.fetch_done && !first_fetch && (state_ff.fetch_cnt == FETCH_WAIT_CYC - 32'h0000_0001);
		// Only the second and third stages are looked at
		intr_hit = state_ff.intr_sync[2] && !state_ff.intr_sync[1]; // R10
		ecc_smi = ecc_is(ecc_msg_valid, ecc_msg_kind, SMM_ECC_SMI); // R04
		ecc_nmi = ecc_is(ecc_msg_valid, ecc_msg_kind, SMM_ECC_NMI); // R04
		ecc_system_error_n = ecc_is(ecc_msg_valid, ecc_msg_kind, SMM_ECC_SYSTEM_ERROR_N); // R04
		ecc_lt = ecc_is(ecc_msg_valid, ecc_msg_kind, SMM_ECC_LT); // R04
		st_set = 8'h00;
		st_set[`SMM_ST_EXP1] = tmr_exp && !state_ff.first;
		st_set[`SMM_ST_EXP2] = tmr_exp && state_ff.first;
		st_set[`SMM_ST_NOFETCH] = fetch_to;
		st_set[`SMM_ST_ECC_SMI] = ecc_smi;
		st_set[`SMM_ST_ECC_NMI] = ecc_nmi;
		st_set[`SMM_ST_ECC_SYSTEM_ERROR_N] = ecc_system_error_n;
		st_set[`SMM_ST_ECC_LT] = ecc_lt;
		st_set[`SMM_ST_INTRUDE] = intr_hit;
	end

	// Waitrequest drops one cycle after the request rises
	assign avs_waitrequest = (avs_read || avs_write) && !state_ff.ack;

	// Next state
	always_comb begin
		nxt_state = state_ff;
		// Bus handshake: one wait cycle per access
		nxt_state.ack = (avs_read || avs_write) && !state_ff.ack;
		if (avs_read && !state_ff.ack) begin
			case (avs_address)
				`SMM_REG_CTRL: nxt_state.rdata = {30'h0000_0000, state_ff.route, state_ff.run};
				`SMM_REG_RELOAD: nxt_state.rdata = state_ff.reload;
				`SMM_REG_STATUS: nxt_state.rdata = {24'h00_0000, state_ff.status};
				`SMM_REG_ENABLE: nxt_state.rdata = {24'h00_0000, state_ff.irq_en};
				`SMM_REG_FDIS: nxt_state.rdata = {25'h000_0000, state_ff.fdis};
				`SMM_REG_COUNT: nxt_state.rdata = state_ff.count;
				// Kick and clear read as zero
				default: nxt_state.rdata = `SMM_ZERO32;
			endcase
		end
		// Status: set beats clear in the same cycle
		nxt_state.status = state_ff.status | st_set;
		if (wr_go) begin
			case (avs_address)
				`SMM_REG_CTRL: begin
					nxt_state.run = avs_writedata[`SMM_CTRL_RUN];
					nxt_state.route = avs_writedata[`SMM_CTRL_ROUTE]; // R08
				end
				`SMM_REG_RELOAD: nxt_state.reload = avs_writedata;
				`SMM_REG_CLEAR: nxt_state.status = (state_ff.status & ~avs_writedata[7:0]) | st_set;
				`SMM_REG_ENABLE: nxt_state.irq_en = avs_writedata[7:0];
				`SMM_REG_FDIS: nxt_state.fdis = avs_writedata[6:0]; // R05
				// Kick (taken by the timer) or read-only: ignored
				default: nxt_state.run = state_ff.run;
			endcase
		end
		// Lockup timer
		if (!state_ff.run) begin
			// Stopped timer sits loaded and unarmed
			nxt_state.count = state_ff.reload;
			nxt_state.first = 1'b0;
		end else if (kick_go) begin
			nxt_state.count = state_ff.reload; // R09
			nxt_state.first = 1'b0; // R09
		end else if (tmr_exp) begin
			nxt_state.count = state_ff.reload;
			// Second expiry rearms for the next cycle after reset
			nxt_state.first = !state_ff.first; // R01 R02
		end else begin
			nxt_state.count = state_ff.count - 32'h0000_0001;
		end
		// First fetch watch, once per reset
		if (!state_ff.fetch_done) begin
			nxt_state.fetch_cnt = state_ff.fetch_cnt + 32'h0000_0001;
			nxt_state.fetch_done = first_fetch || fetch_to; // R03
		end
		// Intrusion synchroniser and edge stage
		nxt_state.intr_sync = {state_ff.intr_sync[1:0], intruder_n}; // R10
		// Event pulses
		nxt_state.smi_n = !(st_set[`SMM_ST_EXP1] || ecc_smi || (intr_hit && !state_ff.route)); // R01 R04 R08
		nxt_state.nmi = ecc_nmi; // R04
		nxt_state.system_error_n_n = !ecc_system_error_n; // R04
		nxt_state.lt_irq = ecc_lt || (intr_hit && state_ff.route); // R04 R08
		nxt_state.sys_rst = st_set[`SMM_ST_EXP2] || fetch_to; // R02 R03
		// Function gating
		nxt_state.fout.claim = func_in.claim & ~state_ff.fdis; // R06
		nxt_state.fout.irq = func_in.irq & ~state_ff.fdis; // R07
		nxt_state.fout.pme = func_in.pme & ~state_ff.fdis; // R07
		nxt_state.irq = |(nxt_state.status & state_ff.irq_en);
	end

	// State register
	always_ff @(posedge clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			state_ff <= '0;
			state_ff.reload <= `SMM_RELOAD_RST;
			state_ff.count <= `SMM_RELOAD_RST;
			state_ff.intr_sync <= 3'h7;
			state_ff.smi_n <= 1'b1;
			state_ff.system_error_n_n <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from flops
	assign avs_readdata = state_ff.rdata;
	assign func_out = state_ff.fout;
	assign system_mgmt_interrupt_n = state_ff.smi_n;
	assign nmi = state_ff.nmi;
	assign system_error_n = state_ff.system_error_n_n;
	assign lockup_timer_irq = state_ff.lt_irq;
	assign sys_reset = state_ff.sys_rst;
	assign irq = state_ff.irq;

	// Checks
	default clocking cb @(posedge clk); endclocking
	// Checks wake one edge after the core, so no attempt sees reset-time history
	default disable iff (!rst_sync_ff[2]);

	first_exp_smi_a: assert property (tmr_exp && !state_ff.first |=> !system_mgmt_interrupt_n && state_ff.first) // R01
		else $error("first expiry gave no smi");
	second_exp_rst_a: assert property (tmr_exp && state_ff.first |=> sys_reset && !state_ff.first) // R02
		else $error("second expiry gave no reset");
	fetch_miss_rst_a: assert property (fetch_to |=> sys_reset ##1 state_ff.fetch_done) // R03
		else $error("missing fetch gave no reboot");
	reset_cause_a: assert property ($rose(sys_reset) |-> $past(tmr_exp && state_ff.first) || $past(fetch_to)) // R02
		else $error("reset without a cause");
	ecc_route_a: assert property (ecc_msg_valid |=> nmi == $past(ecc_msg_kind == SMM_ECC_NMI) // R04
		&& system_error_n == $past(ecc_msg_kind != SMM_ECC_SYSTEM_ERROR_N)
		&& ($past(ecc_msg_kind) != SMM_ECC_SMI || !system_mgmt_interrupt_n)
		&& ($past(ecc_msg_kind) != SMM_ECC_LT || lockup_timer_irq))
		else $error("memory error routed wrongly");
	ecc_nmi_a: assert property (ecc_nmi |=> nmi ##1 (!nmi || $past(ecc_nmi))) // R04
		else $error("nmi pulse wrong");
	claim_gate_a: assert property (##1 func_out.claim == ($past(func_in.claim) & ~$past(state_ff.fdis))) // R06
		else $error("disabled function claimed access");
	irq_gate_a: assert property (##1 ((func_out.irq | func_out.pme) & $past(state_ff.fdis)) == 7'h00) // R07
		else $error("disabled function raised event");
	intrude_route_a: assert property ($fell(state_ff.intr_sync[1]) |=> // R08
		($past(state_ff.route) ? lockup_timer_irq : !system_mgmt_interrupt_n))
		else $error("intrusion routed wrongly");
	// Low sampled at two edges: edge stage fires on the third
	intrude_sync_a: assert property ($fell(intruder_n) && state_ff.intr_sync == 3'h7 ##1 !intruder_n |-> // R10
		!intr_hit ##1 intr_hit)
		else $error("intrusion sync latency wrong");
	// A fetch timeout may still pulse the reset line on its own
	kick_a: assert property (kick_go && state_ff.run |=> // R09
		!state_ff.first && state_ff.count == state_ff.reload && (!sys_reset || $past(fetch_to)))
		else $error("reload did not restart timer");

	first_exp_c: cover property (tmr_exp && !state_ff.first);
	second_exp_c: cover property (tmr_exp && state_ff.first);
	intrude_c: cover property (intr_hit && state_ff.route);
	fetch_ok_c: cover property (!state_ff.fetch_done && first_fetch);

endmodule : smm_monitor
`default_nettype wire

// ===== core/smm_pkg.sv
// Purpose: Types shared by the manageability monitor
// Assumes: Constants come from smm_consts.svh
// Notes: Message kinds follow the memory controller encoding
package smm_pkg;
	// Interrupt chosen by a memory error message
	typedef enum logic [1:0] {
		SMM_ECC_SMI = 2'b00,
		SMM_ECC_NMI = 2'b01,
		SMM_ECC_SYSTEM_ERROR_N = 2'b10,
		SMM_ECC_LT = 2'b11
	} smm_ecc_t;
	// Per-function strobes: network, usb, lpc, audio, sata, pcie, smbus
	typedef struct packed {
		logic [6:0] claim;
		logic [6:0] irq;
		logic [6:0] pme;
	} smm_func_t;
	// Complete module state
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic run;
		logic route;
		logic [31:0] reload;
		logic [31:0] count;
		logic first;
		logic [31:0] fetch_cnt;
		logic fetch_done;
		logic [7:0] status;
		logic [7:0] irq_en;
		logic [6:0] fdis;
		logic [2:0] intr_sync;
		logic smi_n;
		logic nmi;
		logic system_error_n_n;
		logic lt_irq;
		logic sys_rst;
		smm_func_t fout;
		logic irq;
	} smm_state_t;
endpackage : smm_pkg

// ===== testbench/smm_host_model.sv
// Purpose: Host processor and memory controller stand-in
// Assumes: Signals change by non-blocking assignment after rising edges
// Notes: Message kind is scrambled while idle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module smm_host_model
	import smm_pkg::*;
(
	input wire logic clk,
	output logic first_fetch,
	output logic ecc_msg_valid,
	output smm_ecc_t ecc_msg_kind
);
	// Idle levels from time zero
	initial begin
		first_fetch = 1'b0;
		ecc_msg_valid = 1'b0;
		ecc_msg_kind = SMM_ECC_SMI;
	end
	// One fetch pulse once the core is out of reset
	task automatic fetch();
		@(posedge clk);
		first_fetch <= 1'b1;
		@(posedge clk);
		first_fetch <= 1'b0;
	endtask : fetch
	// One error message, one cycle long
	task automatic send_ecc(input smm_ecc_t k);
		@(posedge clk);
		ecc_msg_valid <= 1'b1;
		ecc_msg_kind <= k;
		@(posedge clk);
		ecc_msg_valid <= 1'b0;
		ecc_msg_kind <= smm_ecc_t'(~k);
	endtask : send_ecc
endmodule : smm_host_model
`default_nettype wire

// ===== testbench/smm_monitor_bench.sv
// Purpose: Self-checking bench for the monitor
// Assumes: Fetch wait shortened to 20 cycles
// Notes: Event pulses are tallied at every edge
`include "smm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module smm_monitor_bench;
	import smm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, first_fetch, ecc_msg_valid, smi_n, nmi, system_error_n_n, lt_irq, sys_reset, irq;
	logic intruder_n = 1'b1;
	smm_ecc_t ecc_msg_kind;
	smm_func_t func_in = '1;
	smm_func_t func_out;
	logic [6:0] m;
	int errors = 0;
	int cmp_count = 0;
	// Pulse tallies: smi nmi system_error_n lt reset
	int n[5] = '{default: 0};
	int b[5];
	string nm[5] = '{"smi", "nmi", "system_error_n", "lt", "rst"};
	always #2 clk = ~clk;
	smm_monitor #(.FETCH_WAIT_CYC(32'h0000_0014)) smm_monitor_inst (.clk(clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.first_fetch(first_fetch), .ecc_msg_valid(ecc_msg_valid), .ecc_msg_kind(ecc_msg_kind),
		.intruder_n(intruder_n), .func_in(func_in), .func_out(func_out),
		.system_mgmt_interrupt_n(smi_n), .nmi(nmi), .system_error_n(system_error_n_n),
		.lockup_timer_irq(lt_irq), .sys_reset(sys_reset), .irq(irq));
	smm_host_model smm_host_model_inst (.clk(clk), .first_fetch(first_fetch),
		.ecc_msg_valid(ecc_msg_valid), .ecc_msg_kind(ecc_msg_kind));
	// Count each one-cycle event
	always @(posedge clk) begin
		n[0] <= n[0] + (smi_n === 1'b0);
		n[1] <= n[1] + (nmi === 1'b1);
		n[2] <= n[2] + (system_error_n_n === 1'b0);
		n[3] <= n[3] + (lt_irq === 1'b1);
		n[4] <= n[4] + (sys_reset === 1'b1);
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Event count since the last snapshot
	task automatic dchk(input int i, input int e);
		chk(nm[i], e, n[i] - b[i]);
	endtask : dchk
	// Bus access; waitrequest and read data taken at the same rising edge
	task automatic acc(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// Only the watchdog ends a hung access
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [2:0] a, input logic [31:0] e, input string s);
		acc(1'b0, a, 32'h0000_0000);
		chk(s, e, rd);
	endtask : rc
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// Watchdog well beyond the expected run
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// No fetch after reset: reboot
		repeat (40) @(posedge clk);
		chk("fetch timeout", 32'h0000_0001, n[4]);
		rc(`SMM_REG_STATUS, 32'h0000_0004, "status");
		rc(`SMM_REG_RELOAD, `SMM_RELOAD_RST, "reload");
		rc(`SMM_REG_CTRL, 32'h0000_0000, "ctrl");
		// Second reset mid-run, fetch arrives in time
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		b = n;
		repeat (3) @(posedge clk);
		smm_host_model_inst.fetch();
		repeat (40) @(posedge clk);
		dchk(4, 0);
		// Two expiries: interrupt, then reset
		wr(`SMM_REG_RELOAD, 32'h0000_001E);
		rc(`SMM_REG_COUNT, 32'h0000_001E, "count idle");
		b = n;
		wr(`SMM_REG_CTRL, 32'h0000_0001);
		repeat (40) @(posedge clk);
		dchk(0, 1);
		dchk(4, 0);
		repeat (30) @(posedge clk);
		dchk(4, 1);
		wr(`SMM_REG_CTRL, 32'h0000_0000);
		rc(`SMM_REG_STATUS, 32'h0000_0003, "status");
		// Kicks after the first expiry hold off the reset
		wr(`SMM_REG_CLEAR, 32'h0000_00FF);
		b = n;
		wr(`SMM_REG_CTRL, 32'h0000_0001);
		repeat (40) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (10) @(posedge clk);
			wr(`SMM_REG_KICK, 32'h0000_0000);
		end
		wr(`SMM_REG_CTRL, 32'h0000_0000);
		dchk(0, 1);
		dchk(4, 0);
		rc(`SMM_REG_KICK, 32'h0000_0000, "kick read");
		wr(`SMM_REG_STATUS, 32'h0000_0000);
		rc(`SMM_REG_STATUS, 32'h0000_0001, "status ro");
		// Interrupt level follows enable and clear
		chk("irq masked", 32'h0000_0000, 32'(irq));
		wr(`SMM_REG_ENABLE, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irq on", 32'h0000_0001, 32'(irq));
		wr(`SMM_REG_CLEAR, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irq off", 32'h0000_0000, 32'(irq));
		// Every memory error kind
		b = n;
		for (int k = 0; k < 4; k++) smm_host_model_inst.send_ecc(smm_ecc_t'(k));
		repeat (3) @(posedge clk);
		for (int i = 0; i < 4; i++) dchk(i, 1);
		rc(`SMM_REG_STATUS, 32'h0000_0078, "ecc status");
		// Intrusion on both routes
		wr(`SMM_REG_CLEAR, 32'h0000_00FF);
		for (int r = 0; r < 2; r++) begin
			wr(`SMM_REG_CTRL, 32'(r << 1));
			b = n;
			intruder_n <= 1'b0;
			repeat (8) @(posedge clk);
			intruder_n <= 1'b1;
			repeat (8) @(posedge clk);
			dchk(3 * r, 1);
		end
		rc(`SMM_REG_STATUS, 32'h0000_0080, "intrude");
		// Function disable patterns
		for (int i = 0; i < 2; i++) begin
			m = i ? 7'h2A : 7'h55;
			wr(`SMM_REG_FDIS, 32'(m));
			// First pass uses an uneven request pattern so gating must use the live inputs; second pass drives all ones
			func_in <= smm_func_t'(i ? 21'h1F_FFFF : 21'h0A_5C3F);
			repeat (2) @(posedge clk);
			chk("func_out", 32'(func_in & {3{~m}}), 32'(func_out));
		end
		rc(`SMM_REG_FDIS, 32'h0000_002A, "fdis");
		end_of_test();
	end
endmodule : smm_monitor_bench
`default_nettype wire
